// ===== rtcr_pkg.sv
// Package for the time and calendar register bank: offsets, fields and reset values.
package rtcr_pkg;
   // ======================================================
   // Register offsets
   localparam logic [7:0] RTCR_SCRATCH_OFS = 8'h03;
   localparam logic [7:0] RTCR_SEC_OFS = 8'h04;
   localparam logic [7:0] RTCR_MIN_OFS = 8'h05;
   localparam logic [7:0] RTCR_HOUR_OFS = 8'h06;
   localparam logic [7:0] RTCR_DAY_OFS = 8'h07;
   localparam logic [7:0] RTCR_WDAY_OFS = 8'h08;
   localparam logic [7:0] RTCR_MON_OFS = 8'h09;
   localparam logic [7:0] RTCR_YEAR_OFS = 8'h0A;
   localparam logic [7:0] RTCR_SMATCH_OFS = 8'h0B;
   localparam logic [7:0] RTCR_MMATCH_OFS = 8'h0C;
   // ======================================================
   // Field positions
   localparam int RTCR_OSC_STOP_BIT = 7;
   localparam int RTCR_DISABLE_BIT = 7;
   localparam int RTCR_MERIDIEM_BIT = 5;
   // ======================================================
   // Reset values
   localparam logic [7:0] RTCR_SCRATCH_RST = 8'h00;
   localparam logic [7:0] RTCR_SEC_RST = 8'h80;
   localparam logic [7:0] RTCR_MIN_RST = 8'h00;
   localparam logic [7:0] RTCR_HOUR_RST = 8'h00;
   localparam logic [7:0] RTCR_DAY_RST = 8'h01;
   localparam logic [7:0] RTCR_WDAY_RST = 8'h06;
   localparam logic [7:0] RTCR_MON_RST = 8'h01;
   localparam logic [7:0] RTCR_YEAR_RST = 8'h00;
   localparam logic [7:0] RTCR_MATCH_RST = 8'h80;
   // Number of registers in the register bank.
   localparam int RTCR_NREG = 10;
endpackage

// ===== rtcr_scratch.sv
// Scratch storage byte with registered read data.
`timescale 1ns/1ps
`default_nettype none
module rtcr_scratch (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Write side
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // Read side
   output logic [7:0] rd_data
);
   import rtcr_pkg::*;

   // ======================================================
   // Storage
   // Byte holds host data.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= RTCR_SCRATCH_RST;
      end else if (wr_en) begin
         rd_data <= wr_data;
      end
   end
endmodule
`default_nettype wire

// ===== rtcr_regs.sv
// Time and calendar counter bank with 1 Hz cascade, freeze and match flag.
//
// Contract
// - Scratch byte at 0x03 stores host data, resets to zero.
// - Seconds bit 7 flags oscillator stop, resets to one.
// - Seconds BCD: tens bits 6..4, units bits 3..0, reset zero.
// - Minutes BCD at 0x05, bit 7 reads zero.
// - Twelve-hour: bit 5 meridiem, bit 4 tens, bits 3..0 units.
// - Twenty-four-hour: tens bits 5..4, units 3..0, bits 7..6 zero.
// - Hour format chosen by the format control input.
// - Day of month BCD at 0x07, tens bits 5..4.
// - Year divisible by four gives February a 29th day.
// - Weekday bits 2..0 count 0..6, reset six, upper bits zero.
// - Month BCD at 0x09, 1..12, resets to January.
// - Year two BCD digits at 0x0A, reset zero.
// - Access freezes counters; one pending tick applied afterwards.
// - Second match at 0x0B: bit 7 disable high-active, BCD value.
// - Minute match at 0x0C: bit 7 disable high-active, BCD value.
// - Match flag set when enabled fields first match time.
`timescale 1ns/1ps
`default_nettype none
module rtcr_regs (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Time base and control
   input wire logic tick_1hz,
   input wire logic hour_12_mode,
   input wire logic match_flag_clear,
   // Register port
   input wire logic access_active,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Status
   output logic time_match_flag,
   output logic oscillator_stop_flag
);
   import rtcr_pkg::*;

   // ======================================================
   // Helpers
   // BCD increment of a two-digit value.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      if (v[3:0] == 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction

   // Last day of the month, with the leap year rule.
   function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
      logic [7:0] r;
      logic leap;
      r = 8'h31;
      leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00) : (y[1:0] == 2'b10);
      case (m)
         8'h02: r = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
         default: r = 8'h31;
      endcase
      return r;
   endfunction

   // ======================================================
   // Counter state
   logic osc_stop_r;
   logic [6:0] sec_r;
   logic [6:0] min_r;
   logic [5:0] hour_r;
   logic [5:0] day_r;
   logic [2:0] wday_r;
   logic [4:0] mon_r;
   logic [7:0] year_r;
   logic [7:0] smatch_r;
   logic [7:0] mmatch_r;
   logic pending_r;
   logic [7:0] scratch_q;
   logic scratch_wr;
   logic do_tick;
   logic [7:0] sec_nxt;
   logic [7:0] min_nxt;
   logic [5:0] hour_nxt;
   logic [7:0] hour_inc;
   logic [7:0] day_nxt;
   logic [2:0] wday_nxt;
   logic [7:0] mon_nxt;
   logic [7:0] year_nxt;
   logic carry_min;
   logic carry_hour;
   logic carry_day;
   logic carry_mon;
   logic carry_year;
   logic match_now;
   logic match_prev_r;

   assign scratch_wr = reg_wr && (reg_addr == RTCR_SCRATCH_OFS);

   // The scratch byte lives in its own module.
   rtcr_scratch u_scratch (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_en(scratch_wr),
      .wr_data(reg_wdata),
      .rd_data(scratch_q)
   );

   // ======================================================
   // Tick deferral
   // Ticks during an access wait; only one is kept.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pending_r <= 1'b0;
      end else if (access_active) begin
         if (tick_1hz) begin
            pending_r <= 1'b1;
         end
      end else begin
         // A tick on the release cycle is kept for one more cycle,
         // so the stored tick and the fresh one are both counted.
         pending_r <= pending_r && tick_1hz;
      end
   end

   // Counters advance only outside an access.
   assign do_tick = !access_active && (tick_1hz || pending_r);

   // ======================================================
   // Carry chain
   // Cascade of field increments.
   always_comb begin
      carry_min = (sec_r == 7'h59);
      sec_nxt = carry_min ? 8'h00 : bcd_inc({1'b0, sec_r});
      carry_hour = carry_min && (min_r == 7'h59);
      min_nxt = (min_r == 7'h59) ? 8'h00 : bcd_inc({1'b0, min_r});
      carry_day = 1'b0;
      hour_nxt = hour_r;
      // In twelve-hour mode the tens digit never carries into bit 5, so one increment serves both formats.
      hour_inc = bcd_inc({2'b00, hour_r});
      if (hour_12_mode) begin
         if (hour_r[4:0] == 5'h12) begin
            hour_nxt = {hour_r[5], 5'h01};
         end else if (hour_r[4:0] == 5'h11) begin
            hour_nxt = {~hour_r[5], 5'h12};
            carry_day = hour_r[5];
         end else begin
            hour_nxt = {hour_r[5], hour_inc[4:0]};
         end
      end else begin
         if (hour_r == 6'h23) begin
            hour_nxt = 6'h00;
            carry_day = 1'b1;
         end else begin
            hour_nxt = hour_inc[5:0];
         end
      end
      carry_day = carry_day && carry_hour;
      carry_mon = carry_day && ({2'b00, day_r} == month_last({3'b000, mon_r}, year_r));
      day_nxt = carry_mon ? 8'h01 : bcd_inc({2'b00, day_r});
      // The values carry no day names; the host gives them their meaning.
      // Weekday wraps after six.
      wday_nxt = (wday_r == 3'h6) ? 3'h0 : wday_r + 3'h1;
      carry_year = carry_mon && (mon_r == 5'h12);
      mon_nxt = carry_year ? 8'h01 : bcd_inc({3'b000, mon_r});
      year_nxt = (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
   end

   // ======================================================
   // Time counters
   // A host write wins over a tick in the same cycle; the carry that the tick
   // would have passed on still reaches the higher fields. Hosts write inside
   // an access, where no tick lands, so this only matters for stray writes.
   // Seconds counter and host writes.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sec_r <= RTCR_SEC_RST[6:0];
         osc_stop_r <= RTCR_SEC_RST[RTCR_OSC_STOP_BIT];
      end else if (reg_wr && reg_addr == RTCR_SEC_OFS) begin
         sec_r <= reg_wdata[6:0];
         // Host clears or sets the stop flag.
         osc_stop_r <= reg_wdata[RTCR_OSC_STOP_BIT];
      end else if (do_tick) begin
         sec_r <= sec_nxt[6:0];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         min_r <= RTCR_MIN_RST[6:0];
      end else if (reg_wr && reg_addr == RTCR_MIN_OFS) begin
         min_r <= reg_wdata[6:0];
      end else if (do_tick && carry_min) begin
         min_r <= min_nxt[6:0];
      end
   end

   // Hours counter follows the selected format.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hour_r <= RTCR_HOUR_RST[5:0];
      end else if (reg_wr && reg_addr == RTCR_HOUR_OFS) begin
         hour_r <= reg_wdata[5:0];
      end else if (do_tick && carry_hour) begin
         hour_r <= hour_nxt;
      end
   end

   // Day counter, limited by month length.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         day_r <= RTCR_DAY_RST[5:0];
      end else if (reg_wr && reg_addr == RTCR_DAY_OFS) begin
         day_r <= reg_wdata[5:0];
      end else if (do_tick && carry_day) begin
         day_r <= day_nxt[5:0];
      end
   end

   // Weekday counter, advanced with the day.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wday_r <= RTCR_WDAY_RST[2:0];
      end else if (reg_wr && reg_addr == RTCR_WDAY_OFS) begin
         wday_r <= reg_wdata[2:0];
      end else if (do_tick && carry_day) begin
         wday_r <= wday_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mon_r <= RTCR_MON_RST[4:0];
      end else if (reg_wr && reg_addr == RTCR_MON_OFS) begin
         mon_r <= reg_wdata[4:0];
      end else if (do_tick && carry_mon) begin
         mon_r <= mon_nxt[4:0];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         year_r <= RTCR_YEAR_RST;
      end else if (reg_wr && reg_addr == RTCR_YEAR_OFS) begin
         year_r <= reg_wdata;
      end else if (do_tick && carry_year) begin
         year_r <= year_nxt;
      end
   end

   // ======================================================
   // Match settings
   // Second match setting.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         smatch_r <= RTCR_MATCH_RST;
      end else if (reg_wr && reg_addr == RTCR_SMATCH_OFS) begin
         smatch_r <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mmatch_r <= RTCR_MATCH_RST;
      end else if (reg_wr && reg_addr == RTCR_MMATCH_OFS) begin
         mmatch_r <= reg_wdata;
      end
   end

   // The match is taken on the counter values, so a host write that lands on
   // the setting raises the flag just as a tick would.
   // Disabled fields are ignored; at least one must be enabled.
   assign match_now = (!smatch_r[RTCR_DISABLE_BIT] || !mmatch_r[RTCR_DISABLE_BIT])
      && (smatch_r[RTCR_DISABLE_BIT] || smatch_r[6:0] == sec_r)
      && (mmatch_r[RTCR_DISABLE_BIT] || mmatch_r[6:0] == min_r);

   // Flag sets on the first matching cycle; set wins over clear.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         match_prev_r <= 1'b0;
         time_match_flag <= 1'b0;
      end else begin
         match_prev_r <= match_now;
         if (match_now && !match_prev_r) begin
            time_match_flag <= 1'b1;
         end else if (match_flag_clear) begin
            time_match_flag <= 1'b0;
         end
      end
   end

   // ======================================================
   // Read path
   // Read data is registered so the output comes from a flop.
   // Unused upper bits are padded with zeros here, whatever the host wrote.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            RTCR_SCRATCH_OFS: reg_rdata <= scratch_wr ? reg_wdata : scratch_q;
            RTCR_SEC_OFS: reg_rdata <= {osc_stop_r, sec_r};
            RTCR_MIN_OFS: reg_rdata <= {1'b0, min_r};
            RTCR_HOUR_OFS: reg_rdata <= {2'b00, hour_r};
            RTCR_DAY_OFS: reg_rdata <= {2'b00, day_r};
            RTCR_WDAY_OFS: reg_rdata <= {5'b00000, wday_r};
            RTCR_MON_OFS: reg_rdata <= {3'b000, mon_r};
            RTCR_YEAR_OFS: reg_rdata <= year_r;
            RTCR_SMATCH_OFS: reg_rdata <= smatch_r;
            RTCR_MMATCH_OFS: reg_rdata <= mmatch_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Stop flag mirrored to a port for status.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         oscillator_stop_flag <= 1'b1;
      end else begin
         oscillator_stop_flag <= osc_stop_r;
      end
   end
endmodule
`default_nettype wire

// ===== rtcr_props.sv
// Checker of the register bank port behaviour.
`timescale 1ns/1ps
`default_nettype none
module rtcr_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Host side inputs
   input wire logic match_flag_clear,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // Outputs
   input wire logic [7:0] reg_rdata,
   input wire logic time_match_flag,
   input wire logic oscillator_stop_flag
);
   // ==========================================
   // Assertions, all in the single clock domain.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_scratch_keeps_data: assert property (reg_wr && reg_addr == 8'h03 ##2
      reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(reg_wdata, 3))
      else $error("scratch byte lost data");
   a_stop_flag_read: assert property (reg_rd && reg_addr == 8'h04 |=>
      reg_rdata[7] == oscillator_stop_flag) else $error("stop flag differs");
   a_sec_digits_bcd: assert property (reg_rd && reg_addr == 8'h04 |=>
      reg_rdata[6:4] <= 3'h5 && reg_rdata[3:0] <= 4'h9) else $error("seconds not BCD");
   a_min_top_zero: assert property (reg_rd && reg_addr == 8'h05 |=>
      !reg_rdata[7]) else $error("minutes bit 7 set");
   a_hour_top_zero: assert property (reg_rd && reg_addr == 8'h06 |=>
      reg_rdata[7:6] == 2'h0) else $error("hours top bits set");
   a_day_top_zero: assert property (reg_rd && reg_addr == 8'h07 |=>
      reg_rdata[7:6] == 2'h0) else $error("day top bits set");
   a_wday_in_range: assert property (reg_rd && reg_addr == 8'h08 |=>
      reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] != 3'h7) else $error("weekday out of range");
   a_month_top_zero: assert property (reg_rd && reg_addr == 8'h09 |=>
      reg_rdata[7:5] == 3'h0) else $error("month top bits set");
   a_match_flag_sticky: assert property (time_match_flag && !match_flag_clear |=>
      time_match_flag) else $error("match flag dropped");
   // Main scenarios reached.
   c_sec_read: cover property (reg_rd && reg_addr == 8'h04);
   c_flag_set: cover property ($rose(time_match_flag));
   c_flag_clear: cover property (match_flag_clear && time_match_flag);
endmodule
`default_nettype wire

// ===== rtcr_host.sv
// Host model driving register accesses toward the bank.
`timescale 1ns/1ps
`default_nettype none
module rtcr_host (
   // Clock
   input wire logic sys_clk,
   // Register port
   output var logic access_active,
   output var logic reg_wr,
   output var logic reg_rd,
   output var logic [7:0] reg_addr,
   output var logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // ==========================================
   // Idle state at time zero.
   initial begin
      access_active = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic open_acc();
      @(posedge sys_clk);
      access_active <= 1'b1;
   endtask
   task automatic close_acc();
      @(posedge sys_clk);
      access_active <= 1'b0;
   endtask
   // Released lines show the inverse, so a stale value cannot pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // Read data is taken once the registered answer has landed.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== rtc_time_calendar_registers_tb.sv
// Self-checking bench of the time and calendar register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module rtc_time_calendar_registers_tb;
   import rtcr_pkg::*;
   logic sys_clk, resetn, tick_1hz, hour_12_mode, match_flag_clear;
   wire logic access_active, reg_wr, reg_rd, time_match_flag, oscillator_stop_flag;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int err_total, cmp_count, cycles;
   logic [7:0] v;
   logic [7:0] rst_tab [10] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00,
      8'h80, 8'h80};
   // Rows: mode, then sec..year before and after one tick.
   logic [112:0] cal_tab [8] = '{
      {1'b0, 56'h59592328060204, 56'h00000029000204}, // leap February
      {1'b0, 56'h59592328030201, 56'h00000001040301},
      {1'b0, 56'h59592331051299, 56'h00000001060100}, // year wrap
      {1'b0, 56'h59592330020400, 56'h00000001030500},
      {1'b0, 56'h59590909000723, 56'h00001009000723},
      {1'b1, 56'h59591110010610, 56'h00003210010610}, // into noon
      {1'b1, 56'h59593115010610, 56'h00001216020610}, // midnight
      {1'b1, 56'h59591215010610, 56'h00000115010610}};
   // ==========================================
   // Design, host model and clock.
   rtcr_regs i_dut (.sys_clk(sys_clk), .resetn(resetn), .tick_1hz(tick_1hz),
      .hour_12_mode(hour_12_mode), .match_flag_clear(match_flag_clear),
      .access_active(access_active), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .time_match_flag(time_match_flag),
      .oscillator_stop_flag(oscillator_stop_flag));
   rtcr_host i_host (.sys_clk(sys_clk), .access_active(access_active), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Hang guard, well above the few hundred cycles the tests use.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic set_time(input logic [55:0] t);
      i_host.open_acc();
      for (int i = 0; i < 7; i++) i_host.wr(8'h04 + 8'(i), t[55-8*i -: 8]);
      i_host.close_acc();
   endtask
   task automatic check_time(input logic [55:0] t);
      i_host.open_acc();
      for (int i = 0; i < 7; i++) begin
         i_host.rd(8'h04 + 8'(i), v);
         `CHK(v, t[55-8*i -: 8]) // calendar cascade
      end
      i_host.close_acc();
   endtask
   task automatic pulse_tick();
      @(posedge sys_clk);
      tick_1hz <= 1'b1;
      @(posedge sys_clk);
      tick_1hz <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   // ==========================================
   // Test sequence.
   initial begin
      tick_1hz = 1'b0;
      hour_12_mode = 1'b0;
      match_flag_clear = 1'b0;
      resetn = 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      foreach (rst_tab[i]) begin
         i_host.rd(8'h03 + 8'(i), v);
         `CHK(v, rst_tab[i]) // reset values
      end
      `CHK(oscillator_stop_flag, 1'b1) // stop flag reset
      i_host.wr(8'h0D, 8'hFF);
      i_host.rd(8'h0D, v);
      `CHK(v, 8'h00) // unmapped stays zero
      i_host.wr(8'h03, 8'hA5);
      i_host.wr(8'h03, 8'h5A);
      i_host.rd(8'h03, v);
      `CHK(v, 8'h5A) // scratch keeps data
      $display("test reset and scratch done");
      foreach (cal_tab[i]) begin
         @(posedge sys_clk);
         hour_12_mode <= cal_tab[i][112];
         set_time(cal_tab[i][111:56]);
         pulse_tick();
         check_time(cal_tab[i][55:0]);
      end
      `CHK(oscillator_stop_flag, 1'b0) // cleared by write
      $display("test calendar done");
      @(posedge sys_clk);
      hour_12_mode <= 1'b0;
      set_time(56'h10000101000101);
      i_host.open_acc();
      pulse_tick();
      pulse_tick();
      i_host.rd(8'h04, v);
      `CHK(v, 8'h10) // frozen in access
      i_host.close_acc();
      repeat (4) @(posedge sys_clk);
      i_host.rd(8'h04, v);
      `CHK(v, 8'h11) // one stored tick
      $display("test freeze done");
      i_host.wr(8'h0B, 8'h05);
      i_host.wr(8'h0C, 8'h03);
      set_time(56'h04020101000101);
      pulse_tick();
      `CHK(time_match_flag, 1'b0) // minute differs
      set_time(56'h04030101000101);
      pulse_tick();
      `CHK(time_match_flag, 1'b1) // both match
      @(posedge sys_clk);
      match_flag_clear <= 1'b1;
      @(posedge sys_clk);
      match_flag_clear <= 1'b0;
      repeat (2) @(posedge sys_clk);
      `CHK(time_match_flag, 1'b0) // cleared
      i_host.wr(8'h0C, 8'h83);
      i_host.rd(8'h0C, v);
      `CHK(v, 8'h83) // setting readback
      set_time(56'h04070101000101);
      pulse_tick();
      `CHK(time_match_flag, 1'b1) // disabled field ignored
      $display("test match done");
      complete_run();
   end
endmodule
bind rtcr_regs rtcr_props i_props (.sys_clk(sys_clk), .resetn(resetn),
   .match_flag_clear(match_flag_clear), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .time_match_flag(time_match_flag), .oscillator_stop_flag(oscillator_stop_flag));
`default_nettype wire
